// >>> design/cvr_regs.svh
`ifndef CVR_REGS_SVH
`define CVR_REGS_SVH
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Low-byte register holds value bits 7:0
// - High-byte register holds value bits 15:8
// - Low address alternatively reaches reload low byte
// - High address alternatively reaches reload high byte
// - Reload view select steers both byte addresses
// - Low-byte write clears comparator enable
// - High-byte write sets comparator enable
// - Comparator enable activates module compare
// - Enabled match on equality sets flag
// - Wide PWM select: 0 short, 1 16-bit
//////////////////////////////////////////////////////////////////////////////
`define CVR_CHANNELS    6
`define CVR_ADDR_LOW0   8'hfb
`define CVR_ADDR_HIGH0  8'hfc
`define CVR_ADDR_LOW1   8'he9
`define CVR_ADDR_HIGH1  8'hea
`define CVR_ADDR_LOW2   8'heb
`define CVR_ADDR_HIGH2  8'hec
`define CVR_ADDR_LOW3   8'hed
`define CVR_ADDR_HIGH3  8'hee
`define CVR_ADDR_LOW4   8'hfd
`define CVR_ADDR_HIGH4  8'hfe
`define CVR_ADDR_LOW5   8'hd2
`define CVR_ADDR_HIGH5  8'hd3
`define CVR_VALUE_RESET 16'h0000
`define CVR_BYTE_RESET  8'h00
`endif

// >>> design/cvr_pkg.sv
package cvr_pkg;
  typedef enum logic [1:0] {
    cvr_hit_none,
    cvr_hit_low,
    cvr_hit_high
  } cvr_hit_type;

  typedef struct packed {
    logic       read_strobe;
    logic       write_strobe;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvr_bus_type;

  typedef struct packed {
    logic       hit;
    logic [7:0] rdata;
  } cvr_resp_type;

  typedef struct packed {
    logic comparator_enable;
    logic match_function_enable;
    logic wide_pwm_select;
  } cvr_mode_type;
endpackage : cvr_pkg

// >>> design/cvr_channel.sv
`timescale 1ns/10ps
`include "cvr_regs.svh"
module cvr_channel (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Register access decoded for this module
  input  wire logic                 write_low,
  input  wire logic                 write_high,
  input  wire logic                 reload_view_select,
  input  wire logic [7:0]           wdata,
  // Comparator side
  input  wire logic [15:0]          counter_value,
  input  wire logic                 match_function_enable,
  input  wire logic                 wide_pwm_select,
  // State out
  output logic      [15:0]          compare_value,
  output logic      [15:0]          reload_value,
  output logic                      comparator_enable,
  output logic                      match_event
);
  import cvr_pkg::*;

  logic [15:0] next_compare_value;
  logic [15:0] next_reload_value;
  logic        next_comparator_enable;
  logic        next_match_event;
  logic [15:0] masked_counter;
  logic [15:0] masked_compare;

  always_comb begin
    next_compare_value     = compare_value;
    next_reload_value      = reload_value;
    next_comparator_enable = comparator_enable;
    if (write_low) begin
      if (reload_view_select) begin
        next_reload_value[7:0] = wdata;
      end else begin
        next_compare_value[7:0] = wdata;
      end
      next_comparator_enable = 1'h0;
    end
    if (write_high) begin
      if (reload_view_select) begin
        next_reload_value[15:8] = wdata;
      end else begin
        next_compare_value[15:8] = wdata;
      end
      next_comparator_enable = 1'h1;
    end
    // Short PWM compares only the low byte of counter and value
    if (wide_pwm_select) begin
      masked_counter = counter_value;
      masked_compare = compare_value;
    end else begin
      masked_counter = {8'h00, counter_value[7:0]};
      masked_compare = {8'h00, compare_value[7:0]};
    end
    next_match_event = comparator_enable && match_function_enable
                       && (masked_counter == masked_compare);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      compare_value     <= `CVR_VALUE_RESET;
      reload_value      <= `CVR_VALUE_RESET;
      comparator_enable <= 1'h0;
      match_event       <= 1'h0;
    end else begin
      compare_value     <= next_compare_value;
      reload_value      <= next_reload_value;
      comparator_enable <= next_comparator_enable;
      match_event       <= next_match_event;
    end
  end
endmodule : cvr_channel

// >>> design/cvr_top.sv
`timescale 1ns/10ps
`include "cvr_regs.svh"
module cvr_top (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // Special-function register bus
  input  wire cvr_pkg::cvr_bus_type         bus,
  output cvr_pkg::cvr_resp_type             resp,
  // Configuration from neighbouring registers
  input  wire logic                         reload_view_select,
  input  wire logic [5:0]                   match_function_enable,
  input  wire logic [5:0]                   wide_pwm_select,
  input  wire logic [15:0]                  counter_value,
  // Module state
  output logic      [5:0]                   comparator_enable,
  output logic      [5:0]                   capture_compare_flag_set,
  output logic      [95:0]                  compare_value_flat,
  output logic      [95:0]                  reload_value_flat
);
  import cvr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic cvr_hit_type decode_hit(input logic [7:0] addr, input int ch);
    logic [7:0] low_addr;
    logic [7:0] high_addr;
    case (ch)
      0: begin
        low_addr  = `CVR_ADDR_LOW0;
        high_addr = `CVR_ADDR_HIGH0;
      end
      1: begin
        low_addr  = `CVR_ADDR_LOW1;
        high_addr = `CVR_ADDR_HIGH1;
      end
      2: begin
        low_addr  = `CVR_ADDR_LOW2;
        high_addr = `CVR_ADDR_HIGH2;
      end
      3: begin
        low_addr  = `CVR_ADDR_LOW3;
        high_addr = `CVR_ADDR_HIGH3;
      end
      4: begin
        low_addr  = `CVR_ADDR_LOW4;
        high_addr = `CVR_ADDR_HIGH4;
      end
      default: begin
        low_addr  = `CVR_ADDR_LOW5;
        high_addr = `CVR_ADDR_HIGH5;
      end
    endcase
    if (addr == low_addr) begin
      decode_hit = cvr_hit_low;
    end else if (addr == high_addr) begin
      decode_hit = cvr_hit_high;
    end else begin
      decode_hit = cvr_hit_none;
    end
  endfunction : decode_hit

  logic [5:0]  hit_low;
  logic [5:0]  hit_high;
  logic [15:0] cmp [`CVR_CHANNELS];
  logic [15:0] rld [`CVR_CHANNELS];

  //////////////////////////////////////////////////////////////////////////////
  // Modules
  genvar g;
  generate
    for (g = 0; g < `CVR_CHANNELS; g++) begin : gen_ch
      assign hit_low[g]  = (decode_hit(bus.addr, g) == cvr_hit_low);
      assign hit_high[g] = (decode_hit(bus.addr, g) == cvr_hit_high);
      cvr_channel u_ch (
        .mclk                  (mclk),
        .reset                 (reset),
        .write_low             (bus.write_strobe && hit_low[g]),
        .write_high            (bus.write_strobe && hit_high[g]),
        .reload_view_select    (reload_view_select),
        .wdata                 (bus.wdata),
        .counter_value         (counter_value),
        .match_function_enable (match_function_enable[g]),
        .wide_pwm_select       (wide_pwm_select[g]),
        .compare_value         (cmp[g]),
        .reload_value          (rld[g]),
        .comparator_enable     (comparator_enable[g]),
        .match_event           (capture_compare_flag_set[g])
      );
      assign compare_value_flat[g*16 +: 16] = cmp[g];
      assign reload_value_flat[g*16 +: 16]  = rld[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  cvr_resp_type next_resp;

  always_comb begin
    next_resp = '0;
    for (int i = 0; i < `CVR_CHANNELS; i++) begin
      if (bus.read_strobe && hit_low[i]) begin
        next_resp.hit   = 1'h1;
        next_resp.rdata = reload_view_select ? rld[i][7:0] : cmp[i][7:0];
      end
      if (bus.read_strobe && hit_high[i]) begin
        next_resp.hit   = 1'h1;
        next_resp.rdata = reload_view_select ? rld[i][15:8] : cmp[i][15:8];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
    end
  end
endmodule : cvr_top

// >>> verif/cvr_checker.sv
`timescale 1ns/10ps
`include "cvr_regs.svh"
module cvr_checker (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  reset,
  // Watched ports
  input wire cvr_pkg::cvr_bus_type  bus,
  input wire logic                  reload_view_select,
  input wire logic [5:0]            match_function_enable,
  input wire logic [5:0]            wide_pwm_select,
  input wire logic [15:0]           counter_value,
  input wire logic [5:0]            comparator_enable,
  input wire logic [5:0]            capture_compare_flag_set,
  input wire logic [95:0]           compare_value_flat,
  input wire logic [95:0]           reload_value_flat
);
  import cvr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire w_lo = bus.write_strobe && bus.addr == `CVR_ADDR_LOW0;
  wire w_hi = bus.write_strobe && bus.addr == `CVR_ADDR_HIGH0;
  wire w_h5 = bus.write_strobe && bus.addr == `CVR_ADDR_HIGH5;
  wire rv = reload_view_select;
  low_clear_a: assert property (w_lo |=> !comparator_enable[0])
    else $error("enable not cleared");
  high_set_a: assert property (w_hi |=> comparator_enable[0])
    else $error("enable not set");
  low_byte_a: assert property (w_lo && !rv
    |=> compare_value_flat[7:0] == $past(bus.wdata)) else $error("low byte wrong");
  high_byte_a: assert property (w_hi && !rv
    |=> compare_value_flat[15:8] == $past(bus.wdata)) else $error("high byte wrong");
  reload_low_a: assert property (w_lo && rv
    |=> reload_value_flat[7:0] == $past(bus.wdata)
    && $stable(compare_value_flat[7:0])) else $error("reload low wrong");
  reload_high_a: assert property (w_h5 && rv
    |=> reload_value_flat[95:88] == $past(bus.wdata)) else $error("reload high wrong");
  flag_off_a: assert property (!comparator_enable[0] |=> !capture_compare_flag_set[0])
    else $error("flag while disabled");
  match_set_a: assert property (comparator_enable[0] && match_function_enable[0]
    && wide_pwm_select[0] && counter_value == compare_value_flat[15:0]
    |=> capture_compare_flag_set[0]) else $error("match flag missing");
endmodule : cvr_checker

// >>> verif/counter_array_compare_value_regs_tb.sv
`timescale 1ns/10ps
`include "cvr_regs.svh"
module counter_array_compare_value_regs_tb;
  import cvr_pkg::*;
  logic mclk = 0, reset = 1, rvs = 0;
  cvr_bus_type bus = '0;
  cvr_resp_type resp;
  logic [5:0] mfe = '1, wps = '1, en, flag, exp_en = '0;
  logic [15:0] cnt = '0, cv [6], rv [6];
  logic [95:0] cvf, rvf;
  logic [7:0] lo [6] = '{`CVR_ADDR_LOW0, `CVR_ADDR_LOW1, `CVR_ADDR_LOW2,
                         `CVR_ADDR_LOW3, `CVR_ADDR_LOW4, `CVR_ADDR_LOW5};
  logic [7:0] hi [6] = '{`CVR_ADDR_HIGH0, `CVR_ADDR_HIGH1, `CVR_ADDR_HIGH2,
                         `CVR_ADDR_HIGH3, `CVR_ADDR_HIGH4, `CVR_ADDR_HIGH5};
  int fails = 0, samples_checked = 0;
  always #50 mclk = ~mclk;
  cvr_top dut (.mclk(mclk), .reset(reset), .bus(bus), .resp(resp), .reload_view_select(rvs),
    .match_function_enable(mfe), .wide_pwm_select(wps), .counter_value(cnt),
    .comparator_enable(en), .capture_compare_flag_set(flag), .compare_value_flat(cvf),
    .reload_value_flat(rvf));
  task chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Request stays up for one edge; the next request or an idle bus replaces it
  task op(logic w, logic [7:0] a, logic [7:0] d);
    bus = '{~w, w, a, d};
    @(posedge mclk);
    #1;
  endtask : op
  task wr(int n, logic h, logic [7:0] d);
    rvs = 1'($urandom);
    op(1'h1, h ? hi[n] : lo[n], d);
    if (rvs) rv[n][h*8+:8] = d;
    else cv[n][h*8+:8] = d;
    exp_en[n] = h;
    chk("value", cv[n], cvf[16*n+:16]);
    chk("reload", rv[n], rvf[16*n+:16]);
    chk("enable", {10'h000, exp_en}, {10'h000, en});
  endtask : wr
  task rd(logic [7:0] a, logic [15:0] e);
    op(1'h0, a, 8'h00);
    chk("read", e, {7'h00, resp.hit, resp.rdata});
  endtask : rd
  task summarize;
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    for (int n = 0; n < 6; n++) begin
      cv[n] = '0;
      rv[n] = '0;
    end
    void'($urandom(32'h0a09a2b5));
    repeat (8) @(posedge mclk);
    #1 reset = 0;
    for (int n = 0; n < 6; n++) begin
      rd(lo[n], 16'h0100);
      rd(hi[n], 16'h0100);
    end
    $display("reset values done");
    repeat (4) for (int n = 0; n < 6; n++) begin
      wr(n, 1'h0, 8'($urandom));
      wr(n, 1'h1, 8'($urandom));
      rd(lo[n], {8'h01, rvs ? rv[n][7:0] : cv[n][7:0]});
    end
    rd(8'h00, 16'h0000);
    rd(8'hd4, 16'h0000);
    $display("access done");
    mfe = 6'($urandom) | 6'h01;
    wps = 6'($urandom) | 6'h01;
    repeat (2) for (int n = 0; n < 6; n++) begin
      bus = '0;
      // Odd modules see a counter whose high byte differs: only short PWM matches
      cnt = {cv[n][15:8] ^ {7'h00, n[0]}, cv[n][7:0]};
      @(posedge mclk);
      #1;
      chk("flag", {15'h0000, exp_en[n] & mfe[n] & (~wps[n] | ~n[0])},
          {15'h0000, flag[n]});
      wr(n, 1'h0, 8'($urandom));
    end
    bus = '0;
    $display("match done");
    summarize();
  end
endmodule : counter_array_compare_value_regs_tb
bind cvr_top cvr_checker chk_i (.mclk(mclk), .reset(reset), .bus(bus),
  .reload_view_select(reload_view_select), .match_function_enable(match_function_enable),
  .wide_pwm_select(wide_pwm_select), .counter_value(counter_value),
  .comparator_enable(comparator_enable), .capture_compare_flag_set(capture_compare_flag_set),
  .compare_value_flat(compare_value_flat), .reload_value_flat(reload_value_flat));
